/* File: core/pirf_pkg.sv */
package pirf_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned REQ_W  = 8;
   localparam int unsigned EVT_W  = 9;

   // ----------------------------------------------------------------
   // register offsets (byte addresses, one word each)
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] REQ2_OFS     = 8'h00;
   localparam logic [ADDR_W-1:0] TMA_FLAG_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] ENABLE_OFS   = 8'h08;
   localparam logic [ADDR_W-1:0] GCTRL_OFS    = 8'h0c;
   localparam logic [ADDR_W-1:0] EVT_STAT_OFS = 8'h10;
   localparam logic [ADDR_W-1:0] EVT_MASK_OFS = 8'h14;

   // ----------------------------------------------------------------
   // request register fields
   // ----------------------------------------------------------------
   localparam int unsigned REQ_DT_BIT  = 7;
   localparam int unsigned REQ_AD_BIT  = 6;
   localparam int unsigned REQ_S2_BIT  = 5;
   localparam int unsigned REQ_TG_BIT  = 4;
   localparam int unsigned REQ_TFH_BIT = 3;
   localparam int unsigned REQ_TFL_BIT = 2;
   localparam int unsigned REQ_TC_BIT  = 1;
   localparam int unsigned REQ_TB_BIT  = 0;

   // ----------------------------------------------------------------
   // other fields
   // ----------------------------------------------------------------
   localparam int unsigned TMA_FLAG_BIT   = 0;
   localparam int unsigned EN_TA_BIT      = 0;
   localparam int unsigned EN_DT_BIT      = 1;
   localparam int unsigned GC_PIN_EN_BIT  = 0;
   localparam int unsigned GC_RISE_BIT    = 1;
   localparam int unsigned EVT_TA_BIT     = 8;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [REQ_W-1:0] REQ2_RST     = 8'h00;
   localparam logic [0:0]       TMA_FLAG_RST = 1'h0;
   localparam logic [1:0]       ENABLE_RST   = 2'h0;
   localparam logic [1:0]       GCTRL_RST    = 2'h0;
   localparam logic [EVT_W-1:0] EVT_STAT_RST = 9'h000;
   localparam logic [EVT_W-1:0] EVT_MASK_RST = 9'h000;
   localparam logic [2:0]       PIN_SYNC_RST = 3'h0;

endpackage : pirf_pkg

/* File: core/pirf_flag_bank.sv */
`timescale 1ns/100ps
module pirf_flag_bank
#(
   parameter int unsigned W          = 8,
   parameter logic [W-1:0] RST_VAL   = '0,
   parameter bit          CLR_ON_ONE = 1'b0
)
(
   input  wire logic         mclk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] set_vec,
   input  wire logic         wr_en,
   input  wire logic [W-1:0] wr_bits,
   output logic      [W-1:0] flags_q
);

   // ----------------------------------------------------------------
   // one sticky flag per bit; a set in the clearing cycle wins
   // ----------------------------------------------------------------
   logic [W-1:0] flags_d;

   for (genvar i = 0; i < W; i++)
   begin : g_bit
      logic clr;
      always_comb
      begin
         clr        = wr_en && (wr_bits[i] == CLR_ON_ONE) && flags_q[i];
         flags_d[i] = set_vec[i] | (flags_q[i] & ~clr);
      end
      always_ff @(posedge mclk or negedge arst_n)
      begin
         if (!arst_n)
            flags_q[i] <= RST_VAL[i];
         else
            flags_q[i] <= flags_d[i];
      end
   end

endmodule : pirf_flag_bank

/* File: core/pirf_top.sv */
// How it works
// - timer A wrap sets its request flag
// - timer A enable gates its request
// - direct-transfer enable gates its request
// - request and timer A flags clear by writing 0 only
// - request layout dt,ad,s2,tg,tfh,tfl,tc,tb; reset 0
// - timer B overflow sets its flag
// - serial two done or abort sets flag
// - sleep with direct transfer sets flag
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
module pirf_top
#(
   parameter int unsigned DATA_W = 16
)
(
   input  wire logic                       mclk,
   input  wire logic                       arst_n,
   input  wire logic [pirf_pkg::ADDR_W-1:0] bus_addr,
   input  wire logic [DATA_W-1:0]          bus_wdata,
   input  wire logic                       bus_wr,
   input  wire logic                       bus_rd,
   output logic      [DATA_W-1:0]          bus_rdata_q,
   input  wire logic                       timer_a_wrap,
   input  wire logic                       timer_b_ovf,
   input  wire logic                       timer_c_ovf_up,
   input  wire logic                       timer_c_unf_down,
   input  wire logic                       timer_f_low_match,
   input  wire logic                       timer_f_high_match,
   input  wire logic                       timer_g_capture_pin,
   input  wire logic                       serial_two_done,
   input  wire logic                       serial_two_abort,
   input  wire logic                       adc_busy,
   input  wire logic                       sleep_exec,
   input  wire logic                       direct_transfer_enable,
   input  wire logic                       direct_transfer_taken,
   output logic      [pirf_pkg::REQ_W-1:0] req_flags_q,
   output logic                            timer_a_irq_q,
   output logic                            direct_transfer_irq_q,
   output logic                            irq_q
);
   import pirf_pkg::*;

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (DATA_W < EVT_W)
   begin : g_bad_width
      $error("data width too narrow for event status register");
   end

   if (EVT_W != REQ_W + 1)
   begin : g_bad_evt_width
      $error("event status must hold every request flag and timer a");
   end

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   logic wr_req2;
   logic wr_tma;
   logic wr_en_reg;
   logic wr_gctrl;
   logic wr_evt_stat;
   logic wr_evt_mask;
   // an unmapped offset matches no branch, so its write is dropped;
   // nothing is signalled because the bus has no response path

   always_comb
   begin
      wr_req2     = 1'b0;
      wr_tma      = 1'b0;
      wr_en_reg   = 1'b0;
      wr_gctrl    = 1'b0;
      wr_evt_stat = 1'b0;
      wr_evt_mask = 1'b0;
      if (!bus_wr)
         wr_req2 = 1'b0;
      else if (bus_addr == REQ2_OFS)
         wr_req2 = 1'b1;
      else if (bus_addr == TMA_FLAG_OFS)
         wr_tma = 1'b1;
      else if (bus_addr == ENABLE_OFS)
         wr_en_reg = 1'b1;
      else if (bus_addr == GCTRL_OFS)
         wr_gctrl = 1'b1;
      else if (bus_addr == EVT_STAT_OFS)
         wr_evt_stat = 1'b1;
      else if (bus_addr == EVT_MASK_OFS)
         wr_evt_mask = 1'b1;
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   logic [1:0]       enable_q;
   logic [1:0]       enable_d;
   logic [1:0]       gctrl_q;
   logic [1:0]       gctrl_d;
   logic [EVT_W-1:0] evt_mask_q;
   logic [EVT_W-1:0] evt_mask_d;
   // only the low bits of these words are stored; the upper bits read
   // back as zero

   always_comb
   begin
      enable_d   = enable_q;
      gctrl_d    = gctrl_q;
      evt_mask_d = evt_mask_q;
      if (wr_en_reg)
         enable_d = bus_wdata[1:0];
      if (wr_gctrl)
         gctrl_d = bus_wdata[1:0];
      if (wr_evt_mask)
         evt_mask_d = bus_wdata[EVT_W-1:0];
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         enable_q   <= ENABLE_RST;
         gctrl_q    <= GCTRL_RST;
         evt_mask_q <= EVT_MASK_RST;
      end
      else
      begin
         enable_q   <= enable_d;
         gctrl_q    <= gctrl_d;
         evt_mask_q <= evt_mask_d;
      end
   end

   // ----------------------------------------------------------------
   // capture pin synchroniser and edge detect
   // ----------------------------------------------------------------
   // the pin is asynchronous; a level counts only once stages 1 and 2
   // agree, which also rejects a single-cycle glitch
   logic [2:0] pin_sync_q;
   logic [2:0] pin_sync_d;
   logic       pin_level_q;
   logic       pin_level_d;
   logic       capture_edge;

   always_comb
   begin
      pin_sync_d  = {pin_sync_q[1:0], timer_g_capture_pin};
      pin_level_d = pin_level_q;
      if (pin_sync_q[1] == pin_sync_q[2])
         pin_level_d = pin_sync_q[2];
      capture_edge = 1'b0;
      if (gctrl_q[GC_PIN_EN_BIT] && (pin_level_d != pin_level_q))
         capture_edge = (pin_level_d == gctrl_q[GC_RISE_BIT]);
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_sync_q  <= PIN_SYNC_RST;
         pin_level_q <= 1'b0;
      end
      else
      begin
         pin_sync_q  <= pin_sync_d;
         pin_level_q <= pin_level_d;
      end
   end

   // ----------------------------------------------------------------
   // conversion finish detect
   // ----------------------------------------------------------------
   // finish is taken from the busy status falling, so the flag never
   // rises while the converter still reports activity
   logic adc_busy_q;
   logic adc_finish;

   always_comb
   begin
      adc_finish = adc_busy_q & ~adc_busy;
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         adc_busy_q <= 1'b0;
      else
         adc_busy_q <= adc_busy;
   end

   // ----------------------------------------------------------------
   // request set terms
   // ----------------------------------------------------------------
   logic [REQ_W-1:0] req_set;
   logic [0:0]       tma_set;
   // every event input but the adc_busy level is a one-cycle strobe on this clock, so none is
   // synchronised; the capture pin is the only asynchronous input

   always_comb
   begin
      req_set              = '0;
      req_set[REQ_TB_BIT]  = timer_b_ovf;
      req_set[REQ_TC_BIT]  = timer_c_ovf_up | timer_c_unf_down;
      req_set[REQ_TFL_BIT] = timer_f_low_match;
      req_set[REQ_TFH_BIT] = timer_f_high_match;
      req_set[REQ_TG_BIT]  = capture_edge;
      req_set[REQ_S2_BIT]  = serial_two_done | serial_two_abort;
      req_set[REQ_AD_BIT]  = adc_finish;
      req_set[REQ_DT_BIT]  = sleep_exec & direct_transfer_enable
                             & direct_transfer_taken;
      tma_set              = timer_a_wrap;
   end

   // ----------------------------------------------------------------
   // request flags: software clears by writing 0, cannot set
   // ----------------------------------------------------------------
   logic [0:0]       tma_flag_q;
   logic [EVT_W-1:0] evt_stat_q;
   // the event status below is a second copy of these flags, so clearing
   // one view leaves the other standing

   pirf_flag_bank
   #(
      .W          (REQ_W),
      .RST_VAL    (REQ2_RST),
      .CLR_ON_ONE (1'b0)
   )
   u_req_flags
   (
      .mclk    (mclk),
      .arst_n  (arst_n),
      .set_vec (req_set),
      .wr_en   (wr_req2),
      .wr_bits (bus_wdata[REQ_W-1:0]),
      .flags_q (req_flags_q)
   );

   // timer a keeps a word of its own, so its flag can be cleared without
   // a read-modify-write of the shared request word
   pirf_flag_bank
   #(
      .W          (1),
      .RST_VAL    (TMA_FLAG_RST),
      .CLR_ON_ONE (1'b0)
   )
   u_tma_flag
   (
      .mclk    (mclk),
      .arst_n  (arst_n),
      .set_vec (tma_set),
      .wr_en   (wr_tma),
      .wr_bits (bus_wdata[TMA_FLAG_BIT:TMA_FLAG_BIT]),
      .flags_q (tma_flag_q)
   );

   // ----------------------------------------------------------------
   // event status, write one to clear
   // ----------------------------------------------------------------
   pirf_flag_bank
   #(
      .W          (EVT_W),
      .RST_VAL    (EVT_STAT_RST),
      .CLR_ON_ONE (1'b1)
   )
   u_evt_stat
   (
      .mclk    (mclk),
      .arst_n  (arst_n),
      .set_vec ({tma_set, req_set}),
      .wr_en   (wr_evt_stat),
      .wr_bits (bus_wdata[EVT_W-1:0]),
      .flags_q (evt_stat_q)
   );

   // ----------------------------------------------------------------
   // interrupt outputs
   // ----------------------------------------------------------------
   logic timer_a_irq_d;
   logic direct_transfer_irq_d;
   logic irq_d;
   // lines are registered for clean outputs, so each trails its flag by
   // one cycle and also drops one cycle after the clear

   always_comb
   begin
      timer_a_irq_d         = tma_flag_q[0] & enable_q[EN_TA_BIT];
      direct_transfer_irq_d = req_flags_q[REQ_DT_BIT]
                              & enable_q[EN_DT_BIT];
      irq_d                 = |(evt_stat_q & evt_mask_q);
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         timer_a_irq_q         <= 1'b0;
         direct_transfer_irq_q <= 1'b0;
         irq_q                 <= 1'b0;
      end
      else
      begin
         timer_a_irq_q         <= timer_a_irq_d;
         direct_transfer_irq_q <= direct_transfer_irq_d;
         irq_q                 <= irq_d;
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   // data stands for one cycle only; unmapped reads answer zero
   logic [DATA_W-1:0] bus_rdata_d;

   always_comb
   begin
      bus_rdata_d = '0;
      if (!bus_rd)
         bus_rdata_d = '0;
      else if (bus_addr == REQ2_OFS)
         bus_rdata_d[REQ_W-1:0] = req_flags_q;
      else if (bus_addr == TMA_FLAG_OFS)
         bus_rdata_d[TMA_FLAG_BIT] = tma_flag_q[0];
      else if (bus_addr == ENABLE_OFS)
         bus_rdata_d[1:0] = enable_q;
      else if (bus_addr == GCTRL_OFS)
         bus_rdata_d[1:0] = gctrl_q;
      else if (bus_addr == EVT_STAT_OFS)
         bus_rdata_d[EVT_W-1:0] = evt_stat_q;
      else if (bus_addr == EVT_MASK_OFS)
         bus_rdata_d[EVT_W-1:0] = evt_mask_q;
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         bus_rdata_q <= '0;
      else
         bus_rdata_q <= bus_rdata_d;
   end

endmodule : pirf_top

/* File: testbench/pirf_top_assertions.sv */
`timescale 1ns/100ps
module pirf_top_assertions
#(
   parameter int unsigned DATA_W = 16
)
(
   input wire logic                        mclk,
   input wire logic                        arst_n,
   input wire logic [pirf_pkg::ADDR_W-1:0] bus_addr,
   input wire logic [DATA_W-1:0]           bus_wdata,
   input wire logic                        bus_wr,
   input wire logic                        timer_a_wrap,
   input wire logic                        timer_b_ovf,
   input wire logic                        timer_c_ovf_up,
   input wire logic                        timer_c_unf_down,
   input wire logic                        timer_f_low_match,
   input wire logic                        timer_f_high_match,
   input wire logic                        serial_two_done,
   input wire logic                        serial_two_abort,
   input wire logic                        adc_busy,
   input wire logic                        sleep_exec,
   input wire logic                        direct_transfer_enable,
   input wire logic                        direct_transfer_taken,
   input wire logic [pirf_pkg::REQ_W-1:0]  req_flags_q,
   input wire logic                        timer_a_irq_q,
   input wire logic                        direct_transfer_irq_q
);
   import pirf_pkg::*;
   // --------
   // checks
   // --------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);

   tb_set_a : assert property (timer_b_ovf |=> req_flags_q[REQ_TB_BIT])
      else $error("timer b flag not set");
   tc_set_a : assert property (timer_c_ovf_up || timer_c_unf_down
      |=> req_flags_q[REQ_TC_BIT])
      else $error("timer c flag not set");
   tfl_set_a : assert property (timer_f_low_match |=> req_flags_q[REQ_TFL_BIT])
      else $error("timer f low flag not set");
   tfh_set_a : assert property (timer_f_high_match |=> req_flags_q[REQ_TFH_BIT])
      else $error("timer f high flag not set");
   s2_set_a : assert property (serial_two_done || serial_two_abort
      |=> req_flags_q[REQ_S2_BIT])
      else $error("serial flag not set");
   ad_set_a : assert property ($fell(adc_busy) |-> ##1 req_flags_q[REQ_AD_BIT])
      else $error("adc flag not set");
   dt_set_a : assert property (sleep_exec && direct_transfer_enable
      && direct_transfer_taken |=> req_flags_q[REQ_DT_BIT])
      else $error("direct transfer flag not set");
   no_self_set_a : assert property ($rose(req_flags_q[REQ_TB_BIT])
      |-> $past(timer_b_ovf))
      else $error("flag rose without event");
   w0_clear_a : assert property (bus_wr && bus_addr == REQ2_OFS && !bus_wdata[REQ_TB_BIT]
      && !timer_b_ovf |=> !req_flags_q[REQ_TB_BIT])
      else $error("flag not cleared by zero");
   ta_gate_a : assert property ($rose(timer_a_irq_q)
      |-> $past(bus_wr, 2) || $past(timer_a_wrap, 2))
      else $error("timer a irq rose without cause");
   dt_gate_a : assert property (direct_transfer_irq_q
      |-> $past(req_flags_q[REQ_DT_BIT]))
      else $error("direct irq without flag");
endmodule : pirf_top_assertions

bind pirf_top pirf_top_assertions #(.DATA_W(DATA_W)) u_pirf_top_assertions (
   .mclk(mclk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
   .bus_wr(bus_wr), .timer_a_wrap(timer_a_wrap), .timer_b_ovf(timer_b_ovf),
   .timer_c_ovf_up(timer_c_ovf_up), .timer_c_unf_down(timer_c_unf_down),
   .timer_f_low_match(timer_f_low_match), .timer_f_high_match(timer_f_high_match),
   .serial_two_done(serial_two_done), .serial_two_abort(serial_two_abort),
   .adc_busy(adc_busy), .sleep_exec(sleep_exec),
   .direct_transfer_enable(direct_transfer_enable),
   .direct_transfer_taken(direct_transfer_taken), .req_flags_q(req_flags_q),
   .timer_a_irq_q(timer_a_irq_q), .direct_transfer_irq_q(direct_transfer_irq_q)
);

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   import pirf_pkg::*;
   logic        mclk = 1'b0;
   logic        arst_n = 1'b0;
   logic [7:0]  bus_addr = 8'h00;
   logic [15:0] bus_wdata = 16'h0000;
   logic        bus_wr = 1'b0;
   logic        bus_rd = 1'b0;
   logic        rd_d = 1'b0;
   logic [10:0] ev = 11'h000;
   logic        pin = 1'b0;
   logic        adc_busy = 1'b1;
   logic [1:0]  dt_on = 2'h3;
   logic [15:0] rdata;
   logic [7:0]  flags;
   logic        ta_irq;
   logic        dt_irq;
   logic        irq;
   logic [15:0] expq[$];
   logic [15:0] exp_v;
   logic [15:0] r;
   int          b;
   int          n_fail = 0;
   int          check_count = 0;

   always #20 mclk = ~mclk;

   pirf_top u_pirf_top (
      .mclk(mclk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_q(rdata), .timer_a_wrap(ev[10]),
      .timer_b_ovf(ev[0]), .timer_c_ovf_up(ev[1]), .timer_c_unf_down(ev[8]),
      .timer_f_low_match(ev[2]), .timer_f_high_match(ev[3]), .timer_g_capture_pin(pin),
      .serial_two_done(ev[5]), .serial_two_abort(ev[9]), .adc_busy(adc_busy),
      .sleep_exec(ev[7]), .direct_transfer_enable(dt_on[0]), .direct_transfer_taken(dt_on[1]),
      .req_flags_q(flags), .timer_a_irq_q(ta_irq), .direct_transfer_irq_q(dt_irq),
      .irq_q(irq)
   );

   // --------
   // tasks
   // --------
   task automatic chk(input logic [15:0] got, input logic [15:0] want);
      check_count++;
      if (got !== want)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, want);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge mclk);
      bus_wr    <= 1'b0;
   endtask : wr

   // expectation is queued here, the monitor below compares it
   task automatic rd(input logic [7:0] a, input logic [15:0] want);
      @(posedge mclk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      expq.push_back(want);
      @(posedge mclk);
      bus_rd   <= 1'b0;
   endtask : rd

   // the pin toggles on each call with i of 4; the adc level falls once only
   task automatic fire(input int i);
      @(posedge mclk);
      if (i == 4)
         pin <= ~pin;
      else if (i == 6)
         adc_busy <= 1'b0;
      else
         ev[i] <= 1'b1;
      @(posedge mclk);
      ev <= 11'h000;
      repeat (5) @(posedge mclk);
   endtask : fire

   task automatic summarize;
      if (n_fail == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize

   always @(posedge mclk)
   begin
      if (rd_d)
         chk(rdata, expq.pop_front());
      rd_d <= bus_rd;
   end

   initial
   begin
      repeat (5000) @(posedge mclk);
      n_fail++;
      summarize();
   end

   // --------
   // sequence
   // --------
   initial
   begin
      void'($urandom(13298));
      repeat (12) @(posedge mclk);
      arst_n <= 1'b1;
      for (int a = 0; a <= 32; a += 4)
         rd(a[7:0], 16'h0000);
      wr(GCTRL_OFS, 16'h0003);
      exp_v = 16'h0000;
      for (int i = 0; i < 10; i++)
      begin
         b = (i == 8) ? 1 : (i == 9) ? 5 : i;
         if (i > 7)
         begin
            wr(REQ2_OFS, 16'h00ff ^ (16'h0001 << b));
            rd(REQ2_OFS, exp_v ^ (16'h0001 << b));
         end
         fire(i);
         exp_v[b] = 1'b1;
         rd(REQ2_OFS, exp_v);
      end
      r = 16'($urandom);
      wr(REQ2_OFS, r);
      rd(REQ2_OFS, {8'h00, r[7:0]});
      wr(REQ2_OFS, 16'h0000);
      wr(REQ2_OFS, 16'hffff);
      rd(REQ2_OFS, 16'h0000);
      wr(GCTRL_OFS, 16'h0001);
      fire(4);
      rd(REQ2_OFS, 16'h0010);
      dt_on <= 2'h2;
      fire(7);
      dt_on <= 2'h1;
      fire(7);
      rd(REQ2_OFS, 16'h0010);
      dt_on <= 2'h3;
      fire(10);
      rd(TMA_FLAG_OFS, 16'h0001);
      fire(7);
      chk({15'h0, ta_irq}, 16'h0000);
      chk({15'h0, dt_irq}, 16'h0000);
      wr(ENABLE_OFS, 16'h0003);
      repeat (2) @(posedge mclk);
      chk({15'h0, ta_irq}, 16'h0001);
      chk({15'h0, dt_irq}, 16'h0001);
      wr(ENABLE_OFS, 16'h0001);
      repeat (2) @(posedge mclk);
      chk({15'h0, dt_irq}, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      wr(EVT_MASK_OFS, 16'h01ff);
      repeat (2) @(posedge mclk);
      chk({15'h0, irq}, 16'h0001);
      wr(EVT_MASK_OFS, 16'h0000);
      repeat (2) @(posedge mclk);
      chk({15'h0, irq}, 16'h0000);
      wr(EVT_MASK_OFS, 16'h01ff);
      wr(EVT_STAT_OFS, 16'h01ff);
      repeat (2) @(posedge mclk);
      chk({15'h0, irq}, 16'h0000);
      rd(EVT_STAT_OFS, 16'h0000);
      wr(8'h20, 16'hffff);
      rd(8'h20, 16'h0000);
      repeat (3) @(posedge mclk);
      summarize();
   end
endmodule : tb_top
